// File: logic/uv_trip_pkg.sv
`default_nettype none
package uv_trip_pkg;
  // Time base
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] ADDR_OPERATION = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_HYST = 8'h0C;
  localparam logic [7:0] ADDR_BLK_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_TRIP_DELAY = 8'h14;
  localparam logic [7:0] ADDR_RESET_DELAY = 8'h18;
  localparam logic [7:0] ADDR_MIN_TRIP = 8'h1C;
  localparam logic [7:0] ADDR_MULT = 8'h20;
  localparam logic [7:0] ADDR_CRV_A = 8'h24;
  localparam logic [7:0] ADDR_CRV_B = 8'h28;
  localparam logic [7:0] ADDR_CRV_C = 8'h2C;
  localparam logic [7:0] ADDR_CRV_D = 8'h30;
  localparam logic [7:0] ADDR_CRV_E = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_OP_TIME = 8'h3C;

  // Encodings
  localparam logic [2:0] OPER_ENABLE = 3'h1;
  localparam logic [2:0] OPER_DISABLE = 3'h5;
  localparam logic [1:0] VSEL_PG = 2'h1;
  localparam logic [1:0] VSEL_PP = 2'h2;
  localparam logic [1:0] RCURVE_IMMEDIATE = 2'h1;
  localparam logic [1:0] RCURVE_DEFTIME = 2'h2;
  localparam logic [1:0] TRESET_HOLD = 2'h1;
  localparam logic [1:0] TRESET_RAMP = 2'h2;
  localparam logic [1:0] BMODE_FREEZE = 2'h1;
  localparam logic [1:0] BMODE_ALL = 2'h2;
  localparam logic [1:0] BMODE_TRIP = 2'h3;
  localparam logic [4:0] CURVE_ANSI_DT = 5'h05;
  localparam logic [4:0] CURVE_IEC_DT = 5'h0F;
  localparam logic [4:0] CURVE_INV_A = 5'h15;
  localparam logic [4:0] CURVE_INV_B = 5'h16;
  localparam logic [4:0] CURVE_PROG = 5'h17;

  // Config register layout, bit 0 is phases[0]
  typedef struct packed {
    logic [4:0] curve;
    logic [1:0] block_mode;
    logic [1:0] time_reset;
    logic [1:0] reset_curve;
    logic low_blk_en;
    logic [1:0] volt_sel;
    logic [1:0] phases;
  } cfg_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } phase_volts_t;

  // Reset values
  localparam logic [2:0] RST_OPERATION = 3'h1;
  localparam logic [15:0] RST_CONFIG = 16'h78B9;
  localparam logic [15:0] RST_LEVEL = 16'h0384;
  localparam logic [15:0] RST_HYST = 16'h0028;
  localparam logic [15:0] RST_BLK_LEVEL = 16'h00C8;
  localparam logic [31:0] RST_TRIP_DELAY = 32'h0000003C;
  localparam logic [31:0] RST_RESET_DELAY = 32'h00000014;
  localparam logic [31:0] RST_MIN_TRIP = 32'h0000003C;
  localparam logic [15:0] RST_MULT = 16'h0064;
  localparam logic [31:0] RST_CRV_A = 32'h000003E8;
  localparam logic [15:0] RST_CRV_B = 16'h0064;
  localparam logic [15:0] RST_CRV_C = 16'h0000;
  localparam logic [31:0] RST_CRV_D = 32'h00000000;
  localparam logic [15:0] RST_CRV_E = 16'h03E8;

  // Fixed inverse curve parameters, same units as the user ones
  localparam logic [31:0] INV_A_A = 32'h000003E8;
  localparam logic [15:0] INV_A_B = 16'h0064;
  localparam logic [15:0] INV_A_C = 16'h0000;
  localparam logic [31:0] INV_A_D = 32'h00000000;
  localparam logic [15:0] INV_A_E = 16'h03E8;
  localparam logic [31:0] INV_B_A = 32'h000003E8;
  localparam logic [15:0] INV_B_B = 16'h0064;
  localparam logic [15:0] INV_B_C = 16'h0000;
  localparam logic [31:0] INV_B_D = 32'h00000000;
  localparam logic [15:0] INV_B_E = 16'h07D0;
endpackage
`default_nettype wire

// File: logic/three_phase_undervoltage_trip.sv
`timescale 1ns/1ps
`default_nettype none
module three_phase_undervoltage_trip #(
  parameter int unsigned TICK_CYCLES = uv_trip_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Measured magnitudes and inhibit
  input wire uv_trip_pkg::phase_volts_t volts_pg,
  input wire uv_trip_pkg::phase_volts_t volts_pp,
  input wire logic inhibit,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Protection outputs
  output logic pickup,
  output logic trip,
  output logic [6:0] elapsed_ratio_percent
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [63:0] T_MAX = 64'h00000000FFFFFFFF;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  function automatic logic flag_next(input logic f, input logic [15:0] v,
                                     input logic [15:0] lo, input logic [16:0] hi);
    if (v < lo) begin
      flag_next = 1'b1;
    end else if ({1'b0, v} >= hi) begin
      flag_next = 1'b0;
    end else begin
      flag_next = f;
    end
  endfunction

  // Settings
  logic [2:0] oper_q;
  uv_trip_pkg::cfg_t cfg_q;
  logic [15:0] level_q, hyst_q, blk_level_q, mult_q, crv_b_q, crv_c_q, crv_e_q;
  logic [31:0] trip_delay_q, reset_delay_q, min_trip_q, crv_a_q, crv_d_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oper_q <= uv_trip_pkg::RST_OPERATION;
      cfg_q <= uv_trip_pkg::RST_CONFIG;
      level_q <= uv_trip_pkg::RST_LEVEL;
      hyst_q <= uv_trip_pkg::RST_HYST;
      blk_level_q <= uv_trip_pkg::RST_BLK_LEVEL;
      trip_delay_q <= uv_trip_pkg::RST_TRIP_DELAY;
      reset_delay_q <= uv_trip_pkg::RST_RESET_DELAY;
      min_trip_q <= uv_trip_pkg::RST_MIN_TRIP;
      mult_q <= uv_trip_pkg::RST_MULT;
      crv_a_q <= uv_trip_pkg::RST_CRV_A;
      crv_b_q <= uv_trip_pkg::RST_CRV_B;
      crv_c_q <= uv_trip_pkg::RST_CRV_C;
      crv_d_q <= uv_trip_pkg::RST_CRV_D;
      crv_e_q <= uv_trip_pkg::RST_CRV_E;
    end else if (reg_wr) begin
      unique case (reg_addr)
        uv_trip_pkg::ADDR_OPERATION: oper_q <= reg_wdata[2:0];
        uv_trip_pkg::ADDR_CONFIG: cfg_q <= reg_wdata[15:0];
        uv_trip_pkg::ADDR_LEVEL: level_q <= reg_wdata[15:0];
        uv_trip_pkg::ADDR_HYST: hyst_q <= reg_wdata[15:0];
        uv_trip_pkg::ADDR_BLK_LEVEL: blk_level_q <= reg_wdata[15:0];
        uv_trip_pkg::ADDR_TRIP_DELAY: trip_delay_q <= reg_wdata;
        uv_trip_pkg::ADDR_RESET_DELAY: reset_delay_q <= reg_wdata;
        uv_trip_pkg::ADDR_MIN_TRIP: min_trip_q <= reg_wdata;
        uv_trip_pkg::ADDR_MULT: mult_q <= reg_wdata[15:0];
        uv_trip_pkg::ADDR_CRV_A: crv_a_q <= reg_wdata;
        uv_trip_pkg::ADDR_CRV_B: crv_b_q <= reg_wdata[15:0];
        uv_trip_pkg::ADDR_CRV_C: crv_c_q <= reg_wdata[15:0];
        uv_trip_pkg::ADDR_CRV_D: crv_d_q <= reg_wdata;
        uv_trip_pkg::ADDR_CRV_E: crv_e_q <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Level detection
  uv_trip_pkg::phase_volts_t volts;
  logic [15:0] v [3];
  logic [16:0] band_hi;
  logic [31:0] band_full;
  logic [2:0] flag_q;
  logic low_blk;
  logic [1:0] nflag;

  assign volts = (cfg_q.volt_sel == uv_trip_pkg::VSEL_PG) ? volts_pg : volts_pp;
  assign v[0] = volts.a;
  assign v[1] = volts.b;
  assign v[2] = volts.c;
  assign band_full = 32'(level_q) * (32'd1000 + 32'(hyst_q)) / 32'd1000;
  assign band_hi = band_full[16:0];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        flag_q[i] <= flag_next(flag_q[i], v[i], level_q, band_hi);
      end
    end
  end

  assign low_blk = cfg_q.low_blk_en &&
                   (v[0] < blk_level_q || v[1] < blk_level_q || v[2] < blk_level_q);
  assign nflag = {1'b0, flag_q[0]} + {1'b0, flag_q[1]} + {1'b0, flag_q[2]};

  // Mode decode
  logic enabled, blk_frz, blk_all, blk_trip, is_idmt, start, kill, reached;
  logic [31:0] target;
  logic [31:0] op_cnt_q, rst_cnt_q, op_time_q;
  logic pickup_q, trip_q;

  assign enabled = (oper_q == uv_trip_pkg::OPER_ENABLE);
  assign blk_frz = inhibit && cfg_q.block_mode == uv_trip_pkg::BMODE_FREEZE;
  assign blk_all = inhibit && cfg_q.block_mode == uv_trip_pkg::BMODE_ALL;
  assign blk_trip = inhibit && cfg_q.block_mode == uv_trip_pkg::BMODE_TRIP;
  assign is_idmt = cfg_q.curve == uv_trip_pkg::CURVE_INV_A ||
                   cfg_q.curve == uv_trip_pkg::CURVE_INV_B ||
                   cfg_q.curve == uv_trip_pkg::CURVE_PROG;
  assign kill = !enabled || blk_all || low_blk;
  assign start = !kill && nflag != 2'h0 && (nflag == cfg_q.phases);
  assign target = is_idmt ? op_time_q : trip_delay_q;
  assign reached = op_cnt_q >= target;

  // Inverse operate time
  logic [31:0] ca, cd;
  logic [15:0] cb, cc, ce, umin;
  logic [63:0] ratio, x, pw, tcur, tsc;

  always_comb begin
    unique case (cfg_q.curve)
      uv_trip_pkg::CURVE_INV_A: begin
        {ca, cb, cc, cd, ce} = {uv_trip_pkg::INV_A_A, uv_trip_pkg::INV_A_B,
          uv_trip_pkg::INV_A_C, uv_trip_pkg::INV_A_D, uv_trip_pkg::INV_A_E};
      end
      uv_trip_pkg::CURVE_INV_B: begin
        {ca, cb, cc, cd, ce} = {uv_trip_pkg::INV_B_A, uv_trip_pkg::INV_B_B,
          uv_trip_pkg::INV_B_C, uv_trip_pkg::INV_B_D, uv_trip_pkg::INV_B_E};
      end
      default: begin
        {ca, cb, cc, cd, ce} = {crv_a_q, crv_b_q, crv_c_q, crv_d_q, crv_e_q};
      end
    endcase
    umin = v[0];
    if (v[1] < umin) begin
      umin = v[1];
    end
    if (v[2] < umin) begin
      umin = v[2];
    end
    // Depth below level in per-mille of level
    if (level_q == 16'h0000 || umin >= level_q) begin
      ratio = 64'h0;
    end else begin
      ratio = 64'(level_q - umin) * 64'd1000 / 64'(level_q);
    end
    x = 64'(cb) * ratio / 64'd100;
    if (x > 64'(cc) * 64'd100) begin
      x = x - 64'(cc) * 64'd100;
    end else begin
      x = 64'h0;
    end
    unique case (ce / 16'd1000)
      16'd0: pw = 64'd1000;
      16'd1: pw = x;
      16'd2: pw = x * x / 64'd1000;
      default: pw = x * x / 64'd1000 * x / 64'd1000;
    endcase
    if (pw == 64'h0) begin
      tcur = T_MAX;
    end else begin
      tcur = 64'(ca) * 64'd1000 / pw + 64'(cd);
    end
    if (tcur > T_MAX) begin
      tcur = T_MAX;
    end
    tsc = tcur * 64'(mult_q) / 64'd100;
    if (tsc > T_MAX) begin
      tsc = T_MAX;
    end
    if (tsc < 64'(min_trip_q)) begin
      tsc = 64'(min_trip_q);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_time_q <= uv_trip_pkg::RST_MIN_TRIP;
    end else begin
      op_time_q <= tsc[31:0];
    end
  end

  // Millisecond tick
  logic [TW-1:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Operate timer
  logic inv_imm, rst_done;
  assign inv_imm = is_idmt && cfg_q.reset_curve == uv_trip_pkg::RCURVE_IMMEDIATE;
  assign rst_done = rst_cnt_q >= reset_delay_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_cnt_q <= 32'h0;
    end else if (kill) begin
      op_cnt_q <= 32'h0;
    end else if (start) begin
      if (!blk_frz && tick_q && !reached) begin
        op_cnt_q <= op_cnt_q + 32'h1;
      end
    end else if (pickup_q) begin
      if (inv_imm || rst_done) begin
        op_cnt_q <= 32'h0;
      end else if (is_idmt && cfg_q.time_reset == uv_trip_pkg::TRESET_RAMP &&
                   tick_q && op_cnt_q != 32'h0) begin
        op_cnt_q <= op_cnt_q - 32'h1;
      end
    end else begin
      op_cnt_q <= 32'h0;
    end
  end

  // Reset timer; freeze holds it only under definite time
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_q <= 32'h0;
    end else if (kill || start || !pickup_q) begin
      rst_cnt_q <= 32'h0;
    end else if (tick_q && !rst_done && !(blk_frz && !is_idmt)) begin
      rst_cnt_q <= rst_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pickup_q <= 1'b0;
    end else if (kill) begin
      pickup_q <= 1'b0;
    end else if (start) begin
      pickup_q <= 1'b1;
    end else if (inv_imm || rst_done) begin
      pickup_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_q <= 1'b0;
    end else if (kill) begin
      trip_q <= 1'b0;
    end else if (!blk_frz) begin
      trip_q <= start && reached && !blk_trip;
    end
  end

  // Elapsed ratio
  logic [6:0] ratio_q;
  logic [63:0] pct;
  assign pct = 64'(op_cnt_q) * 64'd100 / ((target == 32'h0) ? 64'd1 : 64'(target));

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ratio_q <= 7'h00;
    end else if (!pickup_q) begin
      ratio_q <= 7'h00;
    end else if (reached || pct > 64'd100) begin
      ratio_q <= 7'h64;
    end else begin
      ratio_q <= pct[6:0];
    end
  end

  // Read port
  logic [31:0] rdata_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
    end else if (!reg_rd) begin
      rdata_q <= 32'h0;
    end else begin
      unique case (reg_addr)
        uv_trip_pkg::ADDR_OPERATION: rdata_q <= {29'h0, oper_q};
        uv_trip_pkg::ADDR_CONFIG: rdata_q <= {16'h0, cfg_q};
        uv_trip_pkg::ADDR_LEVEL: rdata_q <= {16'h0, level_q};
        uv_trip_pkg::ADDR_HYST: rdata_q <= {16'h0, hyst_q};
        uv_trip_pkg::ADDR_BLK_LEVEL: rdata_q <= {16'h0, blk_level_q};
        uv_trip_pkg::ADDR_TRIP_DELAY: rdata_q <= trip_delay_q;
        uv_trip_pkg::ADDR_RESET_DELAY: rdata_q <= reset_delay_q;
        uv_trip_pkg::ADDR_MIN_TRIP: rdata_q <= min_trip_q;
        uv_trip_pkg::ADDR_MULT: rdata_q <= {16'h0, mult_q};
        uv_trip_pkg::ADDR_CRV_A: rdata_q <= crv_a_q;
        uv_trip_pkg::ADDR_CRV_B: rdata_q <= {16'h0, crv_b_q};
        uv_trip_pkg::ADDR_CRV_C: rdata_q <= {16'h0, crv_c_q};
        uv_trip_pkg::ADDR_CRV_D: rdata_q <= crv_d_q;
        uv_trip_pkg::ADDR_CRV_E: rdata_q <= {16'h0, crv_e_q};
        uv_trip_pkg::ADDR_STATUS: rdata_q <= {17'h0, ratio_q, 2'h0, low_blk, flag_q, trip_q,
                                              pickup_q};
        uv_trip_pkg::ADDR_OP_TIME: rdata_q <= op_time_q;
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign pickup = pickup_q;
  assign trip = trip_q;
  assign elapsed_ratio_percent = ratio_q;

  // Checks
  default clocking cb_clk @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence frz_run_s;
    blk_frz && start && !kill;
  endsequence

  sequence dt_drop_s;
    !is_idmt && pickup_q && !start && !kill && !blk_frz;
  endsequence

  off_quiet_a: assert property (!enabled |=> !pickup_q && !trip_q)
    else $error("active while disabled");
  phase_flag_a: assert property (v[0] < level_q |=> flag_q[0])
    else $error("phase not flagged");
  hyst_hold_a: assert property (flag_q[0] && v[0] >= level_q && {1'b0, v[0]} < band_hi
    && $stable(level_q) |=> flag_q[0])
    else $error("flag lost in band");
  low_block_a: assert property (low_blk |=> !pickup_q && !trip_q)
    else $error("pickup under low block");
  pickup_start_a: assert property (start |=> pickup_q)
    else $error("no pickup on start");
  trip_cause_a: assert property ($rose(trip_q) |-> $past(reached) && $past(start))
    else $error("trip without timeout");
  min_time_a: assert property (op_time_q >= $past(min_trip_q))
    else $error("operate time below minimum");
  imm_reset_a: assert property (inv_imm && pickup_q && !start |=> op_cnt_q == 32'h0)
    else $error("immediate reset missed");
  dt_reset_a: assert property (dt_drop_s ##0 rst_done |=> !pickup_q)
    else $error("pickup held past reset delay");
  freeze_hold_a: assert property (frz_run_s |=> $stable(op_cnt_q))
    else $error("timer moved while frozen");
  freeze_trip_a: assert property (frz_run_s ##0 trip_q |=> trip_q)
    else $error("trip dropped while frozen");
  block_all_a: assert property (blk_all |=> op_cnt_q == 32'h0 && !pickup_q && !trip_q)
    else $error("block all leaked");
  block_trip_a: assert property (blk_trip |=> !trip_q)
    else $error("trip under trip block");
  tick_gap_a: assert property ($rose(tick_q) |=> !tick_q [*1])
    else $error("tick too long");
endmodule
`default_nettype wire

// File: tb/uv_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module uv_front_end (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Values commanded by the bench
  input wire uv_trip_pkg::phase_volts_t cmd_pg,
  input wire uv_trip_pkg::phase_volts_t cmd_pp,
  input wire logic cmd_blk,
  // Toward the protection block
  output var uv_trip_pkg::phase_volts_t volts_pg,
  output var uv_trip_pkg::phase_volts_t volts_pp,
  output var logic inhibit
);
  // Nominal magnitudes until the measurement is up
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      volts_pg <= {3{16'h03E8}};
      volts_pp <= {3{16'h03E8}};
      inhibit <= 1'h0;
    end else begin
      volts_pg <= cmd_pg;
      volts_pp <= cmd_pp;
      inhibit <= cmd_blk;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] NOM = 16'h03E8;
  localparam logic [15:0] FLT = 16'h0320;
  localparam uv_trip_pkg::phase_volts_t NV = '{NOM, NOM, NOM};
  localparam uv_trip_pkg::phase_volts_t FA = '{FLT, NOM, NOM};
  logic ref_clk;
  logic sys_rst;
  uv_trip_pkg::phase_volts_t cmd_pg;
  uv_trip_pkg::phase_volts_t cmd_pp;
  logic cmd_blk;
  uv_trip_pkg::phase_volts_t volts_pg;
  uv_trip_pkg::phase_volts_t volts_pp;
  logic inhibit;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic pickup;
  logic trip;
  logic [6:0] elapsed_ratio_percent;
  int err_total;
  int checked;

  uv_front_end uv_front_end_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_pg(cmd_pg), .cmd_pp(cmd_pp),
    .cmd_blk(cmd_blk), .volts_pg(volts_pg), .volts_pp(volts_pp), .inhibit(inhibit)
  );
  three_phase_undervoltage_trip #(.TICK_CYCLES(10)) three_phase_undervoltage_trip_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .volts_pg(volts_pg), .volts_pp(volts_pp),
    .inhibit(inhibit), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pickup(pickup), .trip(trip),
    .elapsed_ratio_percent(elapsed_ratio_percent)
  );

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", w, e, g);
    end
  endtask

  task automatic chk1(input string w, input logic e, input logic g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask

  task automatic chk_rng(input string w, input logic [31:0] lo, input logic [31:0] hi,
                         input logic [31:0] g);
    checked++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_total++;
      $display("Error %s expected %0d..%0d seen %0d", w, lo, hi, g);
    end
  endtask

  task automatic wait_lvl(input bit sel_trip, input logic v, input int bound, output int n);
    n = 0;
    checked++;
    #1;
    while ((sel_trip ? trip : pickup) !== v) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > bound) begin
        err_total++;
        $display("Error %s expected %0b seen %0b", sel_trip ? "trip" : "pickup", v, ~v);
        wrap_up();
      end
    end
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask

  task automatic set_v(input uv_trip_pkg::phase_volts_t g, input uv_trip_pkg::phase_volts_t p);
    @(posedge ref_clk);
    cmd_pg <= g;
    cmd_pp <= p;
  endtask

  task automatic set_blk(input logic b);
    @(posedge ref_clk);
    cmd_blk <= b;
  endtask

  function automatic logic [31:0] cfg(input logic [4:0] cv, input logic [1:0] bm,
      input logic [1:0] rc, input logic lb, input logic [1:0] vs, input logic [1:0] ph);
    uv_trip_pkg::cfg_t c;
    c = '{cv, bm, 2'h1, rc, lb, vs, ph};
    return {16'h0000, c};
  endfunction

  task automatic idle();
    int m;
    set_v(NV, NV);
    wait_lvl(1, 1'h0, 4, m);
    wait_lvl(0, 1'h0, 40, m);
  endtask

  task automatic t_defaults();
    logic [7:0] a [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                           8'h20, 8'h24, 8'h34, 8'h40};
    logic [31:0] e [12] = '{32'h1, 32'h78B9, 32'h384, 32'h28, 32'hC8, 32'h3C, 32'h14,
                            32'h3C, 32'h64, 32'h3E8, 32'h3E8, 32'h0};
    logic [31:0] v;
    wr(8'h38, 32'hFFFF);
    wr(8'h40, 32'hFFFF);
    for (int i = 0; i < 12; i++) begin
      rd(a[i], v);
      chk("reset value", e[i], v);
    end
    rd(8'h38, v);
    chk("status", 32'h0, v);
  endtask

  task automatic t_dt(input logic [4:0] cv);
    int m;
    wr(8'h04, cfg(cv, 2'h0, 2'h1, 1'h1, 2'h1, 2'h1));
    set_v(FA, NV);
    wait_lvl(0, 1'h1, 10, m);
    hold(20);
    chk_rng("ratio", 20, 70, {25'h0, elapsed_ratio_percent});
    set_v(NV, NV);
    hold(8);
    chk1("pickup held", 1'h1, pickup);
    chk1("trip", 1'h0, trip);
    wait_lvl(0, 1'h0, 40, m);
    set_v(FA, NV);
    wait_lvl(0, 1'h1, 10, m);
    wait_lvl(1, 1'h1, 60, m);
    chk_rng("trip time", 38, 53, m);
    idle();
  endtask

  task automatic t_hyst();
    int m;
    logic [31:0] v;
    set_v('{16'h0352, NOM, NOM}, NV);
    wait_lvl(0, 1'h1, 10, m);
    set_v('{16'h0398, NOM, NOM}, NV);
    hold(5);
    rd(8'h38, v);
    chk1("flag in band", 1'h1, v[2]);
    set_v(NV, NV);
    hold(5);
    set_v('{16'h0398, NOM, NOM}, NV);
    hold(5);
    rd(8'h38, v);
    chk1("flag reentry", 1'h0, v[2]);
    idle();
  endtask

  task automatic t_gates();
    int m;
    logic [31:0] v;
    wr(8'h00, 32'h5);
    set_v(FA, NV);
    hold(20);
    chk1("pickup off", 1'h0, pickup);
    wr(8'h00, 32'h1);
    wait_lvl(0, 1'h1, 10, m);
    set_v('{16'h0064, NOM, NOM}, NV);
    hold(20);
    rd(8'h38, v);
    chk1("low block", 1'h1, v[5]);
    chk1("pickup low", 1'h0, pickup);
    wr(8'h04, cfg(5'h0F, 2'h0, 2'h1, 1'h0, 2'h1, 2'h1));
    wait_lvl(0, 1'h1, 10, m);
    wr(8'h04, cfg(5'h0F, 2'h0, 2'h1, 1'h1, 2'h2, 2'h1));
    set_v(FA, NV);
    wait_lvl(0, 1'h0, 40, m);
    set_v(NV, FA);
    wait_lvl(0, 1'h1, 10, m);
    idle();
  endtask

  task automatic t_phases();
    int m;
    wr(8'h04, cfg(5'h0F, 2'h0, 2'h1, 1'h1, 2'h1, 2'h2));
    set_v(FA, NV);
    hold(20);
    chk1("one of two", 1'h0, pickup);
    set_v('{FLT, FLT, NOM}, NV);
    wait_lvl(0, 1'h1, 10, m);
    set_v('{FLT, FLT, FLT}, NV);
    wait_lvl(0, 1'h0, 40, m);
    chk1("trip", 1'h0, trip);
    wr(8'h04, cfg(5'h0F, 2'h0, 2'h1, 1'h1, 2'h1, 2'h3));
    wait_lvl(0, 1'h1, 10, m);
    idle();
  endtask

  task automatic t_block();
    int m;
    wr(8'h04, cfg(5'h0F, 2'h1, 2'h1, 1'h1, 2'h1, 2'h1));
    set_v(FA, NV);
    wait_lvl(0, 1'h1, 10, m);
    hold(15);
    set_blk(1'h1);
    hold(100);
    chk1("frozen trip", 1'h0, trip);
    set_blk(1'h0);
    wait_lvl(1, 1'h1, 45, m);
    set_blk(1'h1);
    hold(5);
    chk1("trip kept", 1'h1, trip);
    set_blk(1'h0);
    idle();
    wr(8'h04, cfg(5'h0F, 2'h2, 2'h1, 1'h1, 2'h1, 2'h1));
    set_v(FA, NV);
    hold(30);
    set_blk(1'h1);
    wait_lvl(0, 1'h0, 3, m);
    set_blk(1'h0);
    wait_lvl(0, 1'h1, 10, m);
    wait_lvl(1, 1'h1, 60, m);
    chk_rng("trip after clear", 38, 53, m);
    idle();
    wr(8'h04, cfg(5'h0F, 2'h3, 2'h1, 1'h1, 2'h1, 2'h1));
    set_blk(1'h1);
    set_v(FA, NV);
    wait_lvl(0, 1'h1, 10, m);
    hold(80);
    chk1("trip blocked", 1'h0, trip);
    set_blk(1'h0);
    wait_lvl(1, 1'h1, 3, m);
    idle();
  endtask

  task automatic t_inverse();
    int m;
    logic [31:0] v;
    logic [4:0] cv [3] = '{5'h15, 5'h16, 5'h17};
    logic [31:0] ot [3] = '{32'h000007D0, 32'h00000FA0, 32'h000007D0};
    wr(8'h1C, 32'h6);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, cfg(cv[i], 2'h0, 2'h1, 1'h1, 2'h1, 2'h1));
      set_v('{16'h01C2, NOM, NOM}, NV);
      wait_lvl(0, 1'h1, 10, m);
      rd(8'h3C, v);
      chk("op time", ot[i], v);
      hold(45);
      chk1("early trip", 1'h0, trip);
      set_v(NV, NV);
      wait_lvl(0, 1'h0, 4, m);
    end
    wr(8'h20, 32'h5);
    wr(8'h18, 32'h14);
    // Ramp-down time reset: time_reset flipped from 1 to 2
    wr(8'h04, cfg(5'h15, 2'h0, 2'h2, 1'h1, 2'h1, 2'h1) ^ 32'h0180);
    set_v('{16'h01C2, NOM, NOM}, NV);
    wait_lvl(0, 1'h1, 10, m);
    rd(8'h3C, v);
    chk("scaled op time", 32'h64, v);
    hold(100);
    chk_rng("ratio rising", 9, 11, {25'h0, elapsed_ratio_percent});
    // Two phases required: drop-off while the fault stays
    wr(8'h04, cfg(5'h15, 2'h0, 2'h2, 1'h1, 2'h1, 2'h2) ^ 32'h0180);
    hold(50);
    chk_rng("ratio ramp", 4, 8, {25'h0, elapsed_ratio_percent});
    chk1("pickup in ramp", 1'h1, pickup);
    wait_lvl(0, 1'h0, 220, m);
    wr(8'h1C, 32'h80);
    rd(8'h3C, v);
    chk("min op time", 32'h80, v);
    wr(8'h18, 32'h2);
    wr(8'h04, cfg(5'h15, 2'h1, 2'h2, 1'h1, 2'h1, 2'h1));
    set_v('{16'h01C2, NOM, NOM}, NV);
    wait_lvl(0, 1'h1, 10, m);
    set_blk(1'h1);
    set_v(NV, NV);
    hold(8);
    chk1("hold reset", 1'h1, pickup);
    wait_lvl(0, 1'h0, 40, m);
    set_blk(1'h0);
  endtask

  task automatic t_reset();
    int m;
    logic [31:0] v;
    wr(8'h04, cfg(5'h0F, 2'h0, 2'h1, 1'h1, 2'h1, 2'h1));
    set_v(FA, NV);
    wait_lvl(1, 1'h1, 70, m);
    @(posedge ref_clk);
    sys_rst <= 1'h1;
    #1;
    chk1("pickup in reset", 1'h0, pickup);
    chk1("trip in reset", 1'h0, trip);
    set_v(NV, NV);
    @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(8'h14, v);
    chk("delay after reset", 32'h3C, v);
  endtask

  initial begin
    err_total = 0;
    checked = 0;
    sys_rst = 1'h1;
    cmd_pg = NV;
    cmd_pp = NV;
    cmd_blk = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_defaults();
    wr(8'h14, 32'h5);
    wr(8'h18, 32'h2);
    t_dt(5'h05);
    t_dt(5'h0F);
    t_hyst();
    t_gates();
    t_phases();
    t_block();
    t_inverse();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
